//--- verilog/hia_pkg.sv
// Constants, register map and types of the hierarchical interrupt aggregator
package hia_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int HIA_DW     = 32;          // APB data width
	localparam int HIA_AW     = 12;          // APB address width
	localparam int HIA_N_CH   = 8;           // Ports
	localparam int HIA_HALF   = 4;           // Ports per half in split mode
	localparam int HIA_N_ISR  = 8;           // Event status registers per port
	localparam int HIA_EW     = 8;           // Bits per status register
	localparam int HIA_CH_AW  = 3;           // Port index width
	localparam int HIA_ISR_AW = 3;           // Status register index width
	localparam int HIA_PAD    = HIA_DW - HIA_EW;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	// 0x000-0x1FC: port in [8:6], mask select in [5], status index in [4:2]
	localparam logic [HIA_AW-1:0] HIA_STAT_BASE = 12'h000;
	localparam logic [HIA_AW-1:0] HIA_SUM_BASE  = 12'h200; // + port*4
	localparam logic [HIA_AW-1:0] HIA_GRP_BASE  = 12'h220; // Per half group
	localparam logic [HIA_AW-1:0] HIA_GCR_BASE  = 12'h240; // + port*4
	localparam logic [HIA_AW-1:0] HIA_MODE_ADDR = 12'h260;
	// Sub-index [4:3] inside the half group; [2] selects the half
	localparam logic [1:0] HIA_SUB_TOP = 2'h0;  // top_channel_pointer
	localparam logic [1:0] HIA_SUB_LKS = 2'h1;  // lock_summary_status
	localparam logic [1:0] HIA_SUB_LKM = 2'h2;  // lock_mask_reg
	localparam logic [1:0] HIA_SUB_IPC = 2'h3;  // irq_pin_config

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int HIA_LOCK_PTR_BIT = 7;        // Lock bit in top pointer
	localparam int HIA_LK_STATE_BIT = 0;        // lock_state_flag
	localparam int HIA_LK_CHG_BIT   = 1;        // lock_change_flag
	localparam int HIA_IPC_VISL_BIT = 2;        // show_masked_lock_mode
	localparam int HIA_GCR_VIS_BIT  = 0;        // show_masked_mode
	localparam int HIA_MODE_SPLIT_BIT = 0;      // legacy_split_mode
	localparam logic [HIA_EW-1:0] HIA_MASK_RST = 8'hFF;
	localparam logic [2:0]        HIA_IPC_RST  = 3'h0;
	localparam logic              HIA_LKM_RST  = 1'b1;

	// drive_type_field codes
	localparam logic [1:0] HIA_DT_OD      = 2'h0;  // Open drain, low active
	localparam logic [1:0] HIA_DT_PP_LOW  = 2'h1;  // Push-pull, low active

	// Decoded register regions
	typedef enum {
		HIA_RG_NONE, HIA_RG_STAT, HIA_RG_MASK, HIA_RG_SUM, HIA_RG_TOP,
		HIA_RG_LKS, HIA_RG_LKM, HIA_RG_IPC, HIA_RG_GCR, HIA_RG_MODE
	} hia_region_t;

endpackage

//--- verilog/hia_ch_if.sv
// Link between the aggregator top and one port's status block
`timescale 1ns/1ps
interface hia_ch_if;
	import hia_pkg::*;

	logic [HIA_N_ISR*HIA_EW-1:0] ev;
	logic                        show_masked_mode;
	logic                        mask_we;
	logic [HIA_ISR_AW-1:0]       isr_sel;
	logic [HIA_EW-1:0]           wdata;
	logic                        rd_hold;
	logic                        rd_done;
	logic                        sum_hold;
	logic [HIA_EW-1:0]           stat_view;
	logic [HIA_EW-1:0]           mask_view;
	logic [HIA_N_ISR-1:0]        summary;

	modport top (
		output ev, show_masked_mode, mask_we, isr_sel, wdata, rd_hold, rd_done, sum_hold,
		input  stat_view, mask_view, summary
	);
	modport chan (
		input  ev, show_masked_mode, mask_we, isr_sel, wdata, rd_hold, rd_done, sum_hold,
		output stat_view, mask_view, summary
	);
endinterface

//--- verilog/hia_channel.sv
// One port: clear-on-read event status, masks and summary pointer
`timescale 1ns/1ps
module hia_channel (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Link to the aggregator
	hia_ch_if.chan    bus
);
	import hia_pkg::*;

	logic [HIA_EW-1:0]    stat_a [HIA_N_ISR];
	logic [HIA_EW-1:0]    mask_a [HIA_N_ISR];
	logic [HIA_N_ISR-1:0] sum_next;
	logic [HIA_N_ISR-1:0] summary_reg;

	// ****************************************************************
	// Status registers
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < HIA_N_ISR; g++) begin : g_isr
			logic [HIA_EW-1:0] set_w;
			logic [HIA_EW-1:0] status_reg;
			logic [HIA_EW-1:0] hold_reg;
			logic [HIA_EW-1:0] mask_reg;
			logic              hit;

			assign hit = (bus.isr_sel == HIA_ISR_AW'(g));
			// Masked events are only kept when shown masked
			assign set_w = bus.ev[g*HIA_EW +: HIA_EW] &
				(bus.show_masked_mode ? {HIA_EW{1'b1}} : ~mask_reg);

			// Frozen while read; events meanwhile wait in hold_reg
			always_ff @(posedge clk_sys) begin
				if (!rstn) begin
					status_reg <= '0;
					hold_reg   <= '0;
				end else if (hit && bus.rd_done) begin
					status_reg <= hold_reg | set_w;
					hold_reg   <= '0;
				end else if (hit && bus.rd_hold) begin
					hold_reg <= hold_reg | set_w;
				end else begin
					status_reg <= status_reg | set_w;
				end
			end

			// Mask register written by software
			always_ff @(posedge clk_sys) begin
				if (!rstn) begin
					mask_reg <= HIA_MASK_RST;
				end else if (hit && bus.mask_we) begin
					mask_reg <= bus.wdata;
				end
			end

			// Pointer holds only unmasked indications
			assign sum_next[g] = |(status_reg & ~mask_reg);
			assign stat_a[g]   = status_reg &
				(bus.show_masked_mode ? {HIA_EW{1'b1}} : ~mask_reg);
			assign mask_a[g]   = mask_reg;
		end
	endgenerate

	// Summary follows the status unless it is being read
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			summary_reg <= '0;
		end else if (!bus.sum_hold) begin
			summary_reg <= sum_next;
		end
	end

	assign bus.stat_view = stat_a[bus.isr_sel];
	assign bus.mask_view = mask_a[bus.isr_sel];
	assign bus.summary   = summary_reg;

endmodule

//--- verilog/hia_irq_aggregator.sv
// Top of the hierarchical interrupt aggregator with its APB register file
`timescale 1ns/1ps
module hia_irq_aggregator (
	// Clock and reset
	input  wire logic                                       clk_sys,
	input  wire logic                                       rstn,
	// APB slave
	input  wire logic                                       psel,
	input  wire logic                                       penable,
	input  wire logic                                       pwrite,
	input  wire logic [hia_pkg::HIA_AW-1:0]                 paddr,
	input  wire logic [hia_pkg::HIA_DW-1:0]                 pwdata,
	input  wire logic [3:0]                                 pstrb,
	output logic      [hia_pkg::HIA_DW-1:0]                 prdata,
	output logic                                            pready,
	output logic                                            pslverr,
	// Event sources, one pulse per event bit
	input  wire logic [hia_pkg::HIA_N_CH*hia_pkg::HIA_N_ISR*hia_pkg::HIA_EW-1:0]
	                                                        event_in,
	// PLL lock level from the clock unit
	input  wire logic                                       pll_lock_in,
	// Interrupt pins
	output logic                                            first_half_irq_o,
	output logic                                            first_half_irq_oe,
	output logic                                            second_half_irq_o,
	output logic                                            second_half_irq_oe
);
	import hia_pkg::*;

	// ****************************************************************
	// APB phase decode
	// ****************************************************************
	hia_region_t           region;
	logic [HIA_CH_AW-1:0]  ch_sel;
	logic                  half_sel;
	logic                  setup;
	logic                  done;
	logic                  wr;
	logic                  rd_phase;
	logic [HIA_DW-1:0]     prdata_reg;
	logic                  pready_reg;
	logic                  pslverr_reg;

	assign setup    = psel && !penable;
	assign done     = psel && penable && pready_reg;
	assign wr       = done && pwrite && pstrb[0];
	assign rd_phase = psel && !pwrite;

	// Address to region; paddr is steady for the whole transfer
	always_comb begin
		region   = HIA_RG_NONE;
		ch_sel   = paddr[4:2];
		half_sel = paddr[2];
		if (paddr[1:0] != 2'h0) begin
			region = HIA_RG_NONE;
		end else if (paddr[11:9] == HIA_STAT_BASE[11:9]) begin
			region = paddr[5] ? HIA_RG_MASK : HIA_RG_STAT;
			ch_sel = paddr[8:6];
		end else if (paddr[11:5] == HIA_SUM_BASE[11:5]) begin
			region = HIA_RG_SUM;
		end else if (paddr[11:5] == HIA_GRP_BASE[11:5]) begin
			unique case (paddr[4:3])
				HIA_SUB_TOP: region = HIA_RG_TOP;
				HIA_SUB_LKS: region = HIA_RG_LKS;
				HIA_SUB_LKM: region = HIA_RG_LKM;
				HIA_SUB_IPC: region = HIA_RG_IPC;
			endcase
		end else if (paddr[11:5] == HIA_GCR_BASE[11:5]) begin
			region = HIA_RG_GCR;
		end else if (paddr == HIA_MODE_ADDR) begin
			region = HIA_RG_MODE;
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	logic                 split_reg;
	logic [HIA_N_CH-1:0]  vis_reg;
	logic [2:0]           ipc_reg [2];
	logic [1:0]           lkmask_reg;

	// Mode selects generic or split operation
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			split_reg <= 1'b0;
		end else if (wr && region == HIA_RG_MODE) begin
			split_reg <= pwdata[HIA_MODE_SPLIT_BIT];
		end
	end

	// Per-port show_masked_mode bits
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			vis_reg <= '0;
		end else if (wr && region == HIA_RG_GCR) begin
			vis_reg[ch_sel] <= pwdata[HIA_GCR_VIS_BIT];
		end
	end

	// Pin config and lock mask, one copy per half
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ipc_reg[0] <= HIA_IPC_RST;
			ipc_reg[1] <= HIA_IPC_RST;
			lkmask_reg <= {2{HIA_LKM_RST}};
		end else if (wr && region == HIA_RG_IPC) begin
			ipc_reg[half_sel] <= pwdata[2:0];
		end else if (wr && region == HIA_RG_LKM) begin
			lkmask_reg[half_sel] <= pwdata[0];
		end
	end

	// ****************************************************************
	// Per-port status blocks
	// ****************************************************************
	logic [HIA_EW-1:0]    stat_v [HIA_N_CH];
	logic [HIA_EW-1:0]    mask_v [HIA_N_CH];
	logic [HIA_N_ISR-1:0] summ   [HIA_N_CH];
	logic [HIA_N_CH-1:0]  chan_pend;

	genvar c;
	generate
		for (c = 0; c < HIA_N_CH; c++) begin : g_ch
			logic     mine;
			hia_ch_if chif ();

			assign mine          = (ch_sel == HIA_CH_AW'(c));
			assign chif.ev       = event_in[c*HIA_N_ISR*HIA_EW +: HIA_N_ISR*HIA_EW];
			assign chif.show_masked_mode      = vis_reg[c];
			assign chif.mask_we  = wr && mine && region == HIA_RG_MASK;
			assign chif.isr_sel  = paddr[4:2];
			assign chif.wdata    = pwdata[HIA_EW-1:0];
			// Hold covers setup and access so no event slips past the read
			assign chif.rd_hold  = rd_phase && mine && region == HIA_RG_STAT;
			assign chif.rd_done  = chif.rd_hold && done;
			assign chif.sum_hold = rd_phase && mine && region == HIA_RG_SUM;
			assign stat_v[c]     = chif.stat_view;
			assign mask_v[c]     = chif.mask_view;
			assign summ[c]       = chif.summary;
			assign chan_pend[c]  = |chif.summary;

			hia_channel u_chan (
				.clk_sys (clk_sys),
				.rstn    (rstn),
				.bus     (chif)
			);
		end
	endgenerate

	// ****************************************************************
	// PLL lock tracking
	// ****************************************************************
	logic       lk_s1_reg;
	logic       lk_s2_reg;
	logic       lk_s3_reg;
	logic       lk_state_reg;
	logic       lk_edge;
	logic [1:0] lk_chg_reg;
	logic [1:0] lock_pend;

	// Pin synchroniser; the level counts once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			lk_s1_reg    <= 1'b0;
			lk_s2_reg    <= 1'b0;
			lk_s3_reg    <= 1'b0;
			lk_state_reg <= 1'b0;
		end else begin
			lk_s1_reg <= pll_lock_in;
			lk_s2_reg <= lk_s1_reg;
			lk_s3_reg <= lk_s2_reg;
			if (lk_s2_reg == lk_s3_reg) begin
				lk_state_reg <= lk_s3_reg;
			end
		end
	end

	assign lk_edge = (lk_s2_reg == lk_s3_reg) && (lk_s3_reg != lk_state_reg);

	genvar h;
	generate
		for (h = 0; h < 2; h++) begin : g_half
			logic chg_set;
			logic chg_clr;

			assign chg_set = lk_edge &&
				(!lkmask_reg[h] || ipc_reg[h][HIA_IPC_VISL_BIT]);
			// Only a change that was read is cleared; a new one wins
			assign chg_clr = done && rd_phase && region == HIA_RG_LKS &&
				half_sel == 1'(h) && prdata_reg[HIA_LK_CHG_BIT];

			always_ff @(posedge clk_sys) begin
				if (!rstn) begin
					lk_chg_reg[h] <= 1'b0;
				end else begin
					lk_chg_reg[h] <= (lk_chg_reg[h] && !chg_clr) || chg_set;
				end
			end

			assign lock_pend[h] = lk_chg_reg[h] && !lkmask_reg[h];
		end
	endgenerate

	// ****************************************************************
	// Channel pointers
	// ****************************************************************
	logic [HIA_EW-1:0] top_reg [2];
	logic [HIA_EW-1:0] top_next [2];

	// Split mode gives each half four ports plus the lock bit
	always_comb begin
		top_next[0] = '0;
		top_next[1] = '0;
		if (split_reg) begin
			top_next[0][HIA_HALF-1:0]     = chan_pend[HIA_HALF-1:0];
			top_next[1][HIA_HALF-1:0]     = chan_pend[HIA_N_CH-1:HIA_HALF];
			top_next[0][HIA_LOCK_PTR_BIT] = lock_pend[0];
			top_next[1][HIA_LOCK_PTR_BIT] = lock_pend[1];
		end else begin
			top_next[0] = chan_pend;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			top_reg[0] <= '0;
			top_reg[1] <= '0;
		end else begin
			top_reg[0] <= top_next[0];
			top_reg[1] <= top_next[1];
		end
	end

	// ****************************************************************
	// Interrupt pins
	// ****************************************************************
	logic [1:0] irq_act;
	logic [1:0] irq_o_reg;
	logic [1:0] irq_oe_reg;

	// In generic mode the lock event reaches the pin outside the pointer
	assign irq_act[0] = (|top_reg[0]) || (!split_reg && lock_pend[0]);
	assign irq_act[1] = split_reg && (|top_reg[1]);

	generate
		for (h = 0; h < 2; h++) begin : g_pin
			always_ff @(posedge clk_sys) begin
				if (!rstn) begin
					irq_o_reg[h]  <= 1'b0;
					irq_oe_reg[h] <= 1'b0;
				end else if (ipc_reg[h][1:0] == HIA_DT_OD) begin
					irq_o_reg[h]  <= 1'b0;
					irq_oe_reg[h] <= irq_act[h];
				end else if (ipc_reg[h][1:0] == HIA_DT_PP_LOW) begin
					irq_o_reg[h]  <= !irq_act[h];
					irq_oe_reg[h] <= 1'b1;
				end else begin
					irq_o_reg[h]  <= irq_act[h];
					irq_oe_reg[h] <= 1'b1;
				end
			end
		end
	endgenerate

	assign first_half_irq_o   = irq_o_reg[0];
	assign first_half_irq_oe  = irq_oe_reg[0];
	assign second_half_irq_o  = irq_o_reg[1];
	assign second_half_irq_oe = irq_oe_reg[1];

	// ****************************************************************
	// APB read data and handshake
	// ****************************************************************
	// Data is captured in the setup cycle, so every access has no wait
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			prdata_reg  <= '0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup && region == HIA_RG_NONE;
			if (setup) begin
				prdata_reg <= '0;
				unique case (region)
					HIA_RG_STAT: prdata_reg <= {{HIA_PAD{1'b0}}, stat_v[ch_sel]};
					HIA_RG_MASK: prdata_reg <= {{HIA_PAD{1'b0}}, mask_v[ch_sel]};
					HIA_RG_SUM:  prdata_reg <= {{HIA_PAD{1'b0}}, summ[ch_sel]};
					HIA_RG_TOP:  prdata_reg <= {{HIA_PAD{1'b0}}, top_reg[half_sel]};
					HIA_RG_LKS: begin
						prdata_reg[HIA_LK_STATE_BIT] <= lk_state_reg;
						prdata_reg[HIA_LK_CHG_BIT]   <= lk_chg_reg[half_sel];
					end
					HIA_RG_LKM:  prdata_reg[0] <= lkmask_reg[half_sel];
					HIA_RG_IPC:  prdata_reg[2:0] <= ipc_reg[half_sel];
					HIA_RG_GCR:  prdata_reg[HIA_GCR_VIS_BIT] <= vis_reg[ch_sel];
					HIA_RG_MODE: prdata_reg[HIA_MODE_SPLIT_BIT] <= split_reg;
					HIA_RG_NONE: prdata_reg <= '0;
				endcase
			end
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

endmodule

//--- testbench/hia_props.sv
// Port-level checks for the hierarchical interrupt aggregator
`timescale 1ns/1ps
module hia_props
	import hia_pkg::*;
(
	// Clock and reset
	input wire logic                         clk_sys,
	input wire logic                         rstn,
	// APB slave side
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [hia_pkg::HIA_AW-1:0]   paddr,
	input wire logic [hia_pkg::HIA_DW-1:0]   pwdata,
	input wire logic [3:0]                   pstrb,
	input wire logic [hia_pkg::HIA_DW-1:0]   prdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	// Event sources and lock level
	input wire logic [hia_pkg::HIA_N_CH*hia_pkg::HIA_N_ISR*hia_pkg::HIA_EW-1:0]
	                                         event_in,
	input wire logic                         pll_lock_in,
	// Interrupt pins
	input wire logic                         first_half_irq_o,
	input wire logic                         first_half_irq_oe,
	input wire logic                         second_half_irq_o,
	input wire logic                         second_half_irq_oe
);
	logic       acc;
	logic       wr_acc;
	logic       act1;
	logic       act2;
	logic [1:0] dt0_reg;
	logic [1:0] dt1_reg;
	logic       split_reg;
	logic [2:0] quiet_reg;
	logic [5:0] acc_sr_reg;
	logic [7:0] cause_sr_reg;
	logic       lock_q_reg;

	// Pin activity depends on the drive type last written
	assign acc    = psel && penable && pready;
	assign wr_acc = acc && pwrite && pstrb[0];
	assign act1   = (dt0_reg == HIA_DT_OD) ? first_half_irq_oe :
		(dt0_reg == HIA_DT_PP_LOW) ? !first_half_irq_o : first_half_irq_o;
	assign act2   = (dt1_reg == HIA_DT_OD) ? second_half_irq_oe :
		(dt1_reg == HIA_DT_PP_LOW) ? !second_half_irq_o : second_half_irq_o;

	// Shadow of pin setup; checks wait until it has settled
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			dt0_reg   <= HIA_DT_OD;
			dt1_reg   <= HIA_DT_OD;
			split_reg <= 1'b0;
			quiet_reg <= 3'h0;
		end else if (wr_acc && paddr inside {12'h238, 12'h23C, 12'h260}) begin
			quiet_reg <= 3'h0;
			if (paddr == 12'h238)
				dt0_reg <= pwdata[1:0];
			if (paddr == 12'h23C)
				dt1_reg <= pwdata[1:0];
			if (paddr == 12'h260)
				split_reg <= pwdata[0];
		end else if (quiet_reg != 3'h6) begin
			quiet_reg <= quiet_reg + 3'h1;
		end
	end

	// Recent accesses and event causes, newest in bit 0
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			acc_sr_reg   <= 6'h00;
			cause_sr_reg <= 8'h00;
			lock_q_reg   <= pll_lock_in;
		end else begin
			acc_sr_reg   <= {acc_sr_reg[4:0], acc};
			cause_sr_reg <= {cause_sr_reg[6:0],
				acc || (|event_in) || (pll_lock_in != lock_q_reg)};
			lock_q_reg   <= pll_lock_in;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_reads_zero_a: assert property (pslverr |-> pready && prdata == '0)
		else $error("error response without zero data");
	od_low_drive_a: assert property (quiet_reg == 3'h6 && dt0_reg == HIA_DT_OD
		|-> !first_half_irq_o) else $error("open drain pin drives high");
	pp_enable_a: assert property (quiet_reg == 3'h6 && dt0_reg != HIA_DT_OD
		|-> first_half_irq_oe) else $error("push-pull pin not driven");
	drop_after_read_a: assert property (quiet_reg == 3'h6 && $fell(act1)
		|-> |acc_sr_reg) else $error("interrupt dropped without access");
	rise_has_cause_a: assert property (quiet_reg == 3'h6 && $rose(act1)
		|-> |cause_sr_reg) else $error("interrupt raised without cause");
	half2_generic_idle_a: assert property (quiet_reg == 3'h6 && !split_reg
		|-> !act2) else $error("second pin active in generic mode");

	cover property ($rose(act1));
	cover property (pslverr);
	cover property (quiet_reg == 3'h6 && split_reg && act2);
endmodule

//--- testbench/hia_host_model.sv
// Host side of the interrupt pins: board pull-ups and seen levels
`timescale 1ns/1ps
module hia_host_model (
	// Pins from the device
	input  wire logic irq1_o,
	input  wire logic irq1_oe,
	input  wire logic irq2_o,
	input  wire logic irq2_oe,
	// Levels the host samples
	output logic      irq1_lvl,
	output logic      irq2_lvl
);
	// A released pin floats up to the pull-up level
	assign irq1_lvl = irq1_oe ? irq1_o : 1'b1;
	assign irq2_lvl = irq2_oe ? irq2_o : 1'b1;
endmodule

//--- testbench/hia_irq_aggregator_tb.sv
// Self-checking bench for the hierarchical interrupt aggregator
`timescale 1ns/1ps
module hia_irq_aggregator_tb;
	import hia_pkg::*;

	logic                              clk_sys;
	logic                              rstn;
	logic                              psel;
	logic                              penable;
	logic                              pwrite;
	logic [HIA_AW-1:0]                 paddr;
	logic [HIA_DW-1:0]                 pwdata;
	logic [3:0]                        pstrb;
	logic [HIA_DW-1:0]                 prdata;
	logic                              pready;
	logic                              pslverr;
	logic [HIA_N_CH*HIA_N_ISR*HIA_EW-1:0] event_in;
	logic                              pll_lock_in;
	logic                              i1_o;
	logic                              i1_oe;
	logic                              i2_o;
	logic                              i2_oe;
	logic                              lvl1;
	logic                              lvl2;
	logic [HIA_DW-1:0]                 rd;
	logic                              err;
	int                                mismatches;
	int                                checked;

	hia_irq_aggregator u_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.event_in(event_in), .pll_lock_in(pll_lock_in),
		.first_half_irq_o(i1_o), .first_half_irq_oe(i1_oe),
		.second_half_irq_o(i2_o), .second_half_irq_oe(i2_oe));
	hia_host_model u_host (.irq1_o(i1_o), .irq1_oe(i1_oe), .irq2_o(i2_o),
		.irq2_oe(i2_oe), .irq1_lvl(lvl1), .irq2_lvl(lvl2));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic check(input logic [HIA_DW-1:0] got, exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
		end
	endtask

	// One APB transfer; answer and data are taken at the pready edge
	task automatic apb(input logic w, input logic [HIA_AW-1:0] a,
			input logic [HIA_DW-1:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// No wait count is assumed here; only the watchdog ends a hang
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		// Slave answers in the first access cycle, no wait states
		check(32'(n), 32'h1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [HIA_AW-1:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h000000, d});
	endtask

	task automatic rdc(input logic [HIA_AW-1:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h00000000);
		check(rd, {24'h000000, e});
	endtask

	task automatic pulse(input int ch, isr, input logic [7:0] b);
		@(posedge clk_sys);
		event_in[ch*64+isr*8 +: 8] <= b;
		@(posedge clk_sys);
		event_in <= '0;
	endtask

	// Pipeline to the pins is a few clocks; leave margin
	task automatic settle;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task automatic pins(input logic e1, e2);
		settle();
		check(32'({lvl1, lvl2}), 32'({e1, e2}));
	endtask

	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ************************************************************
	// Clock, watchdog and tests
	// ************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Tests need a few hundred clocks; this is ample
	initial begin
		#100000;
		mismatches++;
		conclude();
	end

	initial begin
		rstn        = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = '0;
		pwdata      = '0;
		pstrb       = 4'hF;
		event_in    = '0;
		pll_lock_in = 1'b0;
		mismatches  = 0;
		checked     = 0;
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		// Reset values and an unmapped address
		rdc(12'h020, 8'hFF);
		rdc(12'h230, 8'h01);
		rdc(12'h238, 8'h00);
		apb(1'b0, 12'h300, 32'h00000000);
		check(32'(err), 32'h1);
		// Masked event stays hidden and quiet
		pulse(2, 3, 8'h02);
		rdc(12'h08C, 8'h00);
		pins(1'b1, 1'b1);
		// Hierarchical service of port 2
		wr(12'h0AC, 8'hFD);
		wr(12'h0B4, 8'hFD);
		pulse(2, 3, 8'h12);
		pulse(2, 5, 8'h02);
		pins(1'b0, 1'b1);
		rdc(12'h220, 8'h04);
		rdc(12'h208, 8'h28);
		rdc(12'h08C, 8'h02);
		settle();
		rdc(12'h208, 8'h20);
		pins(1'b0, 1'b1);
		// Event arriving with the read is kept
		fork
			apb(1'b0, 12'h094, 32'h00000000);
			pulse(2, 5, 8'h02);
		join
		check(rd, 32'h00000002);
		rdc(12'h094, 8'h02);
		pins(1'b1, 1'b1);
		rdc(12'h220, 8'h00);
		// Show-masked mode on port 1
		wr(12'h244, 8'h01);
		rdc(12'h244, 8'h01);
		wr(12'h060, 8'hFE);
		pulse(1, 0, 8'h81);
		pins(1'b0, 1'b1);
		rdc(12'h204, 8'h01);
		rdc(12'h040, 8'h81);
		rdc(12'h040, 8'h00);
		pulse(1, 0, 8'h80);
		pins(1'b1, 1'b1);
		rdc(12'h204, 8'h00);
		rdc(12'h040, 8'h80);
		// Every drive type with a request pending
		pulse(1, 0, 8'h01);
		for (int dt = 0; dt < 4; dt++) begin
			wr(12'h238, 8'(dt));
			settle();
			check(32'({i1_oe, i1_o}), 32'({1'b1, dt[1]}));
		end
		wr(12'h238, 8'h01);
		rdc(12'h040, 8'h01);
		settle();
		check(32'({i1_oe, i1_o}), 32'h3);
		wr(12'h238, 8'h00);
		// Split mode: own pin and drive type per half
		wr(12'h260, 8'h01);
		rdc(12'h260, 8'h01);
		wr(12'h23C, 8'h01);
		wr(12'h160, 8'hFE);
		pulse(5, 0, 8'h01);
		pins(1'b1, 1'b0);
		rdc(12'h224, 8'h02);
		rdc(12'h140, 8'h01);
		pins(1'b1, 1'b1);
		// Lock change reaches both halves
		wr(12'h230, 8'h00);
		wr(12'h234, 8'h00);
		pll_lock_in <= 1'b1;
		settle();
		pins(1'b0, 1'b0);
		rdc(12'h220, 8'h80);
		rdc(12'h224, 8'h80);
		rdc(12'h228, 8'h03);
		rdc(12'h228, 8'h01);
		pins(1'b1, 1'b0);
		rdc(12'h22C, 8'h03);
		pins(1'b1, 1'b1);
		// Generic mode: bit 7 is port 7, lock kept apart
		wr(12'h260, 8'h00);
		wr(12'h230, 8'h01);
		wr(12'h1E0, 8'hFE);
		pulse(7, 0, 8'h01);
		pins(1'b0, 1'b1);
		rdc(12'h220, 8'h80);
		rdc(12'h1C0, 8'h01);
		pll_lock_in <= 1'b0;
		settle();
		pins(1'b1, 1'b1);
		rdc(12'h228, 8'h00);
		wr(12'h238, 8'h04);
		pll_lock_in <= 1'b1;
		settle();
		pins(1'b1, 1'b1);
		rdc(12'h228, 8'h03);
		rdc(12'h228, 8'h01);
		conclude();
	end
endmodule

bind hia_irq_aggregator hia_props u_props (.clk_sys(clk_sys), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .event_in(event_in), .pll_lock_in(pll_lock_in),
	.first_half_irq_o(first_half_irq_o), .first_half_irq_oe(first_half_irq_oe),
	.second_half_irq_o(second_half_irq_o),
	.second_half_irq_oe(second_half_irq_oe));
